//--- apt_card.sv
// card end of the command/response transport: header intake, procedure bytes, status
// assumes an application that decides each header and feeds response bytes
//
// How it works
// - outside block mode, le zero or too long answers 6C avail
// - abnormal case 2 never returns 90 00
// - le equals avail sends data then status
// - le below avail sends le, then 61
// - outside block mode, case 4 ends 61xx or non-9000 status
// - acknowledge byte equals the instruction code
// - outside block mode, case 4 select returns 61 with length
// - short get response ends 61 remaining
// - exact get response ends 90 00
// - bad P1/P2 returns 6B 00, no data
// - block mode carries whole units unframed except le below avail, which ends 61
// - case 1 returns status only
// - terminal sets block mode per command from req_t1
// - get response length within announced count
// - terminal retries case 4 warnings with le 00
`timescale 1ns/1ps
`include "apt_params.svh"

module apt_card #(
	parameter int BUF_W = 8,
	parameter int BUF_DEPTH = 2
) (
	input wire logic mclk,
	input wire logic arst_n,
	apt_link_if.card lnk,
	output logic cmd_valid,
	output logic cmd_phase,
	output logic [7:0] cmd_cla,
	output logic [7:0] cmd_ins,
	output logic [7:0] cmd_p1,
	output logic [7:0] cmd_p2,
	output logic [7:0] cmd_p3,
	output logic cmd_dvalid,
	output logic [7:0] cmd_data,
	input wire logic dec_valid,
	input wire logic dec_ok,
	input wire logic dec_bad_param,
	input wire logic dec_read,
	input wire logic dec_case4,
	input wire logic [7:0] dec_avail,
	input wire logic [15:0] dec_sw,
	input wire logic rd_valid,
	input wire logic [BUF_W-1:0] rd_data,
	output logic rd_ready
);

	if (BUF_W != 8 || BUF_DEPTH != 2) begin : g_check
		$error("apt_card: buffer must be 8 bits wide and 2 deep");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	apt_pkg::apt_card_state_t state;
	apt_pkg::apt_card_state_t next_state;
	logic [7:0] hdr [0:4];
	logic [2:0] idx;
	logic [8:0] cnt;
	logic [7:0] pend;
	logic [15:0] sw;
	logic t1;
	logic rd_dir;
	logic c4;
	logic b0_v;
	logic [BUF_W-1:0] b0_d;
	logic [BUF_W-1:0] b1_d;

	assign cmd_cla = hdr[0];
	assign cmd_ins = hdr[1];
	assign cmd_p1 = hdr[2];
	assign cmd_p2 = hdr[3];
	assign cmd_p3 = hdr[4];

	////////////////////////////////////////////////////////////////////////////
	// decoding

	wire [7:0] ins = hdr[1];
	wire [7:0] p3 = hdr[4];
	wire rx_take = lnk.t2c_valid && lnk.t2c_ready;
	wire slot_free = !lnk.c2t_valid || lnk.c2t_ready;
	wire txd_go = state == apt_pkg::C_TXD && slot_free && b0_v;
	wire sw_state = state == apt_pkg::C_SW1 || state == apt_pkg::C_SW2;
	wire out_go = (slot_free && (state == apt_pkg::C_ACK || sw_state)) || txd_go;
	wire buf_push = rd_valid && rd_ready;
	wire is_gr = ins == `APT_INS_GET_RESP;
	wire [7:0] avail = is_gr ? pend : dec_avail;
	wire ok = is_gr ? (pend != 8'h00) : dec_ok;
	wire dec_go = state == apt_pkg::C_DEC && (is_gr || dec_valid);
	wire dec2_go = state == apt_pkg::C_DEC2 && dec_valid;
	wire rd = is_gr || dec_read;
	wire le_bad = p3 == 8'h00 || p3 > avail;
	wire [7:0] n_out = le_bad ? avail : p3;
	wire [7:0] rest = avail - n_out;
	wire [15:0] final_sw = is_gr ? `APT_SW_OK : dec_sw;
	// abnormal path: parameter fault first, otherwise never the normal pair
	wire [15:0] bad_sw = (!is_gr && dec_bad_param) ? `APT_SW_BAD_PARAM :
		((!is_gr && dec_sw != `APT_SW_OK) ? dec_sw : `APT_SW_FAIL);
	// case 4 without data may not end on the normal pair
	wire [15:0] c4_sw = (c4 && dec_sw == `APT_SW_OK) ? `APT_SW_FAIL : dec_sw;
	wire [7:0] out_byte = state == apt_pkg::C_ACK ? ins :
		state == apt_pkg::C_SW1 ? sw[15:8] :
		state == apt_pkg::C_SW2 ? sw[7:0] : b0_d;

	////////////////////////////////////////////////////////////////////////////
	// sequence

	always_comb begin
		next_state = state;
		unique case (state)
			apt_pkg::C_HDR: begin
				if (rx_take && idx == `APT_HDR_LAST) begin
					next_state = apt_pkg::C_DEC;
				end
			end
			apt_pkg::C_DEC: begin
				if (dec_go) begin
					if (!ok) begin
						next_state = apt_pkg::C_SW1;
					end else if (rd) begin
						if ((!t1 && le_bad) || n_out == 8'h00) begin
							next_state = apt_pkg::C_SW1;
						end else begin
							next_state = t1 ? apt_pkg::C_TXD : apt_pkg::C_ACK;
						end
					end else if (p3 == 8'h00) begin
						next_state = apt_pkg::C_DEC2;
					end else begin
						next_state = t1 ? apt_pkg::C_RXD : apt_pkg::C_ACK;
					end
				end
			end
			apt_pkg::C_ACK: begin
				if (out_go) begin
					next_state = rd_dir ? apt_pkg::C_TXD : apt_pkg::C_RXD;
				end
			end
			apt_pkg::C_RXD: begin
				if (rx_take && cnt == 9'h001) begin
					next_state = apt_pkg::C_DEC2;
				end
			end
			apt_pkg::C_DEC2: begin
				if (dec2_go) begin
					if (!dec_ok || dec_avail == 8'h00 || !t1) begin
						next_state = apt_pkg::C_SW1;
					end else begin
						next_state = apt_pkg::C_TXD;
					end
				end
			end
			apt_pkg::C_TXD: begin
				if (txd_go && cnt == 9'h001) begin
					next_state = apt_pkg::C_SW1;
				end
			end
			apt_pkg::C_SW1: begin
				if (out_go) begin
					next_state = apt_pkg::C_SW2;
				end
			end
			apt_pkg::C_SW2: begin
				if (out_go) begin
					next_state = apt_pkg::C_HDR;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= apt_pkg::C_HDR;
			lnk.t2c_ready <= 1'b1;
		end else begin
			state <= next_state;
			lnk.t2c_ready <= next_state == apt_pkg::C_HDR || next_state == apt_pkg::C_RXD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// header, counts and status

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 5; i++) begin
				hdr[i] <= 8'h00;
			end
			idx <= 3'h0;
			t1 <= 1'b0;
		end else if (state == apt_pkg::C_HDR && rx_take) begin
			hdr[idx] <= lnk.t2c_data;
			idx <= (idx == `APT_HDR_LAST) ? 3'h0 : idx + 3'h1;
			if (idx == 3'h0) begin
				t1 <= lnk.t1_mode;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 9'h000;
			pend <= 8'h00;
			sw <= 16'h0000;
			rd_dir <= 1'b0;
			c4 <= 1'b0;
		end else if (dec_go) begin
			rd_dir <= rd;
			c4 <= dec_case4;
			pend <= 8'h00;
			if (!ok) begin
				sw <= bad_sw;
			end else if (rd && !t1 && le_bad) begin
				sw <= {`APT_SW1_WRONG_LE, avail};
			end else if (rd) begin
				cnt <= {1'b0, n_out};
				if (rest != 8'h00) begin
					sw <= {`APT_SW1_MORE, rest};
					pend <= rest;
				end else begin
					sw <= final_sw;
				end
			end else begin
				cnt <= {1'b0, p3};
			end
		end else if (dec2_go) begin
			if (!dec_ok) begin
				sw <= bad_sw;
			end else if (dec_avail == 8'h00) begin
				sw <= c4_sw;
			end else if (!t1) begin
				sw <= {`APT_SW1_MORE, dec_avail};
				pend <= dec_avail;
			end else begin
				sw <= dec_sw;
				cnt <= {1'b0, dec_avail};
			end
		end else if ((state == apt_pkg::C_RXD && rx_take) || txd_go) begin
			cnt <= cnt - 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command data to the application

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_valid <= 1'b0;
			cmd_phase <= 1'b0;
			cmd_dvalid <= 1'b0;
			cmd_data <= 8'h00;
		end else begin
			cmd_valid <= (state == apt_pkg::C_HDR && rx_take && idx == `APT_HDR_LAST &&
				hdr[1] != `APT_INS_GET_RESP) ||
				(next_state == apt_pkg::C_DEC2 && state != apt_pkg::C_DEC2);
			if (next_state == apt_pkg::C_DEC2 && state != apt_pkg::C_DEC2) begin
				cmd_phase <= 1'b1;
			end else if (next_state == apt_pkg::C_DEC) begin
				cmd_phase <= 1'b0;
			end
			cmd_dvalid <= state == apt_pkg::C_RXD && rx_take;
			if (state == apt_pkg::C_RXD && rx_take) begin
				cmd_data <= lnk.t2c_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// two-entry response buffer; rd_ready holds the second slot free

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			b0_v <= 1'b0;
			b0_d <= '0;
			b1_d <= '0;
			rd_ready <= 1'b1;
		end else if (txd_go) begin
			if (!rd_ready) begin
				b0_d <= b1_d;
				rd_ready <= 1'b1;
			end else begin
				b0_v <= buf_push;
				b0_d <= rd_data;
			end
		end else if (buf_push) begin
			if (!b0_v) begin
				b0_v <= 1'b1;
				b0_d <= rd_data;
			end else begin
				b1_d <= rd_data;
				rd_ready <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outgoing byte register

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lnk.c2t_valid <= 1'b0;
			lnk.c2t_data <= 8'h00;
			lnk.c2t_stat <= 1'b0;
		end else if (out_go) begin
			lnk.c2t_valid <= 1'b1;
			lnk.c2t_data <= out_byte;
			lnk.c2t_stat <= sw_state;
		end else if (lnk.c2t_ready) begin
			lnk.c2t_valid <= 1'b0;
		end
	end

endmodule // apt_card

//--- apt_link_assertions.sv
// concurrent checks on the byte link between terminal end and card end
// assumes the testbench ties its inputs to the link interface signals
`timescale 1ns/1ps
`include "apt_params.svh"

module apt_link_assertions (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic t2c_valid,
	input wire logic [7:0] t2c_data,
	input wire logic t2c_ready,
	input wire logic c2t_valid,
	input wire logic [7:0] c2t_data,
	input wire logic c2t_stat,
	input wire logic c2t_ready,
	input wire logic t1_mode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	logic t_take, c_take, sw_end, sw_half, c_first;
	logic [2:0] t_cnt;
	logic [7:0] ins, last_sw1, last_sw2;
	assign t_take = t2c_valid && t2c_ready;
	assign c_take = c2t_valid && c2t_ready;
	assign sw_end = c_take && c2t_stat && sw_half;

	// byte index since the last status pair, first reply flag
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{sw_half, c_first, t_cnt, ins, last_sw1, last_sw2} <= {2'b01, 3'h0, 24'h00_0000};
		end else begin
			if (c_take && c2t_stat) sw_half <= !sw_half;
			if (c_take && c2t_stat && !sw_half) last_sw1 <= c2t_data;
			if (sw_end) last_sw2 <= c2t_data;
			if (sw_end) t_cnt <= 3'h0;
			else if (t_take && t_cnt != 3'h7) t_cnt <= t_cnt + 3'h1;
			if (sw_end) c_first <= 1'b1;
			else if (c_take) c_first <= 1'b0;
			if (t_take && t_cnt == 3'h1) ins <= t2c_data;
		end
	end

	////////////////////////////////////////////////////////////////
	a_status_class:
		assert property (c_take && c2t_stat && !sw_half |-> c2t_data[7:4] inside {4'h6, 4'h9})
		else $error("first status byte outside the 6x and 9x ranges");
	a_pair_unbroken:
		assert property (c_take && sw_half |-> c2t_stat)
		else $error("data byte between the two status bytes");
	a_ack_is_ins:
		assert property (c_take && c_first && !c2t_stat && !t1_mode |-> c2t_data == ins)
		else $error("acknowledge byte differs from the instruction");
	a_status_only:
		assert property (c_take && c2t_stat && !sw_half && c2t_data inside {8'h6B, 8'h6C} |-> c_first)
		else $error("length or parameter status after other bytes");
	a_reissue_ins:
		assert property (t_take && t_cnt == 3'h1 && last_sw1 == 8'h6C && !t1_mode |-> t2c_data == ins)
		else $error("reissued header has another instruction");
	a_reissue_len:
		assert property (t_take && t_cnt == 3'h4 && last_sw1 == 8'h6C && !t1_mode
			|-> t2c_data == last_sw2)
		else $error("reissued header length differs from the offered one");
	a_fetch_ins:
		assert property (t_take && t_cnt == 3'h1 && last_sw1 == 8'h61 && !t1_mode
			|-> t2c_data == 8'hC0)
		else $error("announced data not fetched by get response");
	a_fetch_len:
		assert property (t_take && t_cnt == 3'h4 && last_sw1 == 8'h61 && last_sw2 != 8'h00
			&& !t1_mode |-> t2c_data <= last_sw2)
		else $error("get response asks more than announced");
	a_reply_soon:
		assert property (t_take && t_cnt == 3'h4 && !t1_mode |-> ##[1:16] c2t_valid)
		else $error("no reply to a header");
	a_block_no_proc:
		assert property (c_take && c2t_stat && !sw_half && t1_mode |-> !(c2t_data inside {8'h61, 8'h6C}))
		else $error("procedure bytes in block mode");
endmodule // apt_link_assertions

//--- apt_link_if.sv
// byte link between terminal transport and card transport, one clock
// assumes both ends run on the same mclk; the testbench instantiates it
`timescale 1ns/1ps

interface apt_link_if;
	logic t2c_valid;
	logic [7:0] t2c_data;
	logic t2c_ready;
	logic c2t_valid;
	logic [7:0] c2t_data;
	logic c2t_stat;
	logic c2t_ready;
	logic t1_mode;

	modport card (
		input t2c_valid,
		input t2c_data,
		output t2c_ready,
		output c2t_valid,
		output c2t_data,
		output c2t_stat,
		input c2t_ready,
		input t1_mode
	);

	modport term (
		output t2c_valid,
		output t2c_data,
		input t2c_ready,
		input c2t_valid,
		input c2t_data,
		input c2t_stat,
		output c2t_ready,
		output t1_mode
	);
endinterface

//--- apt_params.svh
// constants of the command/response byte transport: codes, lengths, status words
// assumes inclusion by the package and by both ends of the link
`ifndef APT_PARAMS_SVH
`define APT_PARAMS_SVH

`define APT_HDR_LEN 3'h5
`define APT_HDR_LAST 3'h4
`define APT_PB_NULL 8'h60
`define APT_SW1_MORE 8'h61
`define APT_SW1_WARN_A 8'h62
`define APT_SW1_WARN_B 8'h63
`define APT_SW1_WRONG_LE 8'h6C
`define APT_SW1_NIBBLE_6 4'h6
`define APT_SW1_NIBBLE_9 4'h9
`define APT_INS_GET_RESP 8'hC0
`define APT_SW_OK 16'h9000
`define APT_SW_BAD_PARAM 16'h6B00
`define APT_SW_FAIL 16'h6F00
`define APT_LE_MAX 9'h100

`endif

//--- apt_pkg.sv
// types and byte classification shared by the card end and the terminal end
// assumes apt_params.svh is on the include path
`include "apt_params.svh"

package apt_pkg;

	typedef enum logic [2:0] {
		C_HDR, C_DEC, C_ACK, C_RXD, C_DEC2, C_TXD, C_SW1, C_SW2
	} apt_card_state_t;

	typedef enum logic [2:0] {
		T_IDLE, T_HDR, T_PROC, T_SW2, T_WDATA, T_RDATA, T_T1RD
	} apt_term_state_t;

	typedef enum logic [2:0] {
		PB_NULL, PB_ACK, PB_ACK1, PB_STAT, PB_BAD
	} apt_pb_t;

	// byte after a header: wait, acknowledge, one-byte acknowledge or status
	function automatic apt_pb_t apt_classify(input logic [7:0] b, input logic [7:0] ins);
		apt_pb_t r;
		r = PB_BAD;
		if (b == `APT_PB_NULL) begin
			r = PB_NULL;
		end else if (b == ins) begin
			r = PB_ACK;
		end else if (b == ~ins) begin
			r = PB_ACK1;
		end else if (b[7:4] == `APT_SW1_NIBBLE_6 || b[7:4] == `APT_SW1_NIBBLE_9) begin
			r = PB_STAT;
		end
		return r;
	endfunction

endpackage

//--- apt_term.sv
// terminal end of the command/response transport: sends headers and data, follows
// procedure bytes, reissues headers and fetches pending data
// assumes a user that supplies one command at a time and takes every response byte
`timescale 1ns/1ps
`include "apt_params.svh"

module apt_term (
	input wire logic mclk,
	input wire logic arst_n,
	apt_link_if.term lnk,
	input wire logic req_valid,
	input wire logic [7:0] req_cla,
	input wire logic [7:0] req_ins,
	input wire logic [7:0] req_p1,
	input wire logic [7:0] req_p2,
	input wire logic [7:0] req_p3,
	input wire logic req_write,
	input wire logic req_case4,
	input wire logic req_t1,
	output logic req_ready,
	input wire logic wd_valid,
	input wire logic [7:0] wd_data,
	output logic wd_take,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic done,
	output logic [15:0] done_sw
);

	apt_pkg::apt_term_state_t state;
	apt_pkg::apt_term_state_t next_state;
	logic [7:0] hdr [0:4];
	logic [2:0] idx;
	logic [8:0] rem;
	logic one;
	logic wr;
	logic c4;
	logic grd;
	logic [7:0] sw1;

	////////////////////////////////////////////////////////////////////////////
	// decoding

	wire [7:0] b = lnk.c2t_data;
	wire rx_take = lnk.c2t_valid && lnk.c2t_ready;
	wire slot_free = !lnk.t2c_valid || lnk.t2c_ready;
	wire start = state == apt_pkg::T_IDLE && req_valid;
	wire hdr_go = state == apt_pkg::T_HDR && slot_free;
	wire wd_go = state == apt_pkg::T_WDATA && slot_free && wd_valid && !wd_take;
	wire data_last = rem == 9'h001 || one;
	wire apt_pkg::apt_pb_t pb = apt_pkg::apt_classify(b, hdr[1]);
	wire sw_ok = sw1 == `APT_SW_OK >> 8 && b == 8'h00;
	wire warn = sw1 == `APT_SW1_WARN_A || sw1 == `APT_SW1_WARN_B ||
		(sw1[7:4] == `APT_SW1_NIBBLE_9 && !sw_ok);
	wire retry_le = state == apt_pkg::T_SW2 && rx_take && sw1 == `APT_SW1_WRONG_LE;
	wire fetch = state == apt_pkg::T_SW2 && rx_take && sw1 == `APT_SW1_MORE;
	wire refetch = state == apt_pkg::T_SW2 && rx_take && c4 && !grd && warn &&
		!retry_le && !fetch;
	wire is_ack = pb == apt_pkg::PB_ACK || pb == apt_pkg::PB_ACK1;

	////////////////////////////////////////////////////////////////////////////
	// sequence

	always_comb begin
		next_state = state;
		unique case (state)
			apt_pkg::T_IDLE: begin
				if (start) begin
					next_state = apt_pkg::T_HDR;
				end
			end
			apt_pkg::T_HDR: begin
				if (hdr_go && idx == `APT_HDR_LAST) begin
					if (!lnk.t1_mode) begin
						next_state = apt_pkg::T_PROC;
					end else begin
						next_state = (wr && hdr[4] != 8'h00) ? apt_pkg::T_WDATA : apt_pkg::T_T1RD;
					end
				end
			end
			apt_pkg::T_PROC: begin
				if (rx_take && is_ack) begin
					next_state = wr ? apt_pkg::T_WDATA : apt_pkg::T_RDATA;
				end else if (rx_take && pb != apt_pkg::PB_NULL) begin
					next_state = apt_pkg::T_SW2;
				end
			end
			apt_pkg::T_WDATA: begin
				if (wd_go && data_last) begin
					next_state = lnk.t1_mode ? apt_pkg::T_T1RD : apt_pkg::T_PROC;
				end
			end
			apt_pkg::T_RDATA: begin
				if (rx_take && data_last) begin
					next_state = apt_pkg::T_PROC;
				end
			end
			apt_pkg::T_T1RD: begin
				if (rx_take && lnk.c2t_stat) begin
					next_state = apt_pkg::T_SW2;
				end
			end
			apt_pkg::T_SW2: begin
				if (retry_le || fetch || refetch) begin
					next_state = apt_pkg::T_HDR;
				end else if (rx_take) begin
					next_state = apt_pkg::T_IDLE;
				end
			end
			default: begin
				next_state = apt_pkg::T_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= apt_pkg::T_IDLE;
			req_ready <= 1'b1;
			lnk.c2t_ready <= 1'b0;
		end else begin
			state <= next_state;
			req_ready <= next_state == apt_pkg::T_IDLE;
			lnk.c2t_ready <= next_state == apt_pkg::T_PROC || next_state == apt_pkg::T_SW2 ||
				next_state == apt_pkg::T_RDATA || next_state == apt_pkg::T_T1RD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// header and counters

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 5; i++) begin
				hdr[i] <= 8'h00;
			end
			idx <= 3'h0;
			rem <= 9'h000;
			one <= 1'b0;
			wr <= 1'b0;
			c4 <= 1'b0;
			grd <= 1'b0;
			sw1 <= 8'h00;
			lnk.t1_mode <= 1'b0;
		end else begin
			if (start) begin
				hdr[0] <= req_cla;
				hdr[1] <= req_ins;
				hdr[2] <= req_p1;
				hdr[3] <= req_p2;
				hdr[4] <= req_p3;
				wr <= req_write;
				c4 <= req_case4;
				grd <= 1'b0;
				lnk.t1_mode <= req_t1;
			end
			if (hdr_go) begin
				idx <= (idx == `APT_HDR_LAST) ? 3'h0 : idx + 3'h1;
				rem <= (hdr[4] == 8'h00) ? `APT_LE_MAX : {1'b0, hdr[4]};
			end
			if (state == apt_pkg::T_PROC && rx_take) begin
				one <= pb == apt_pkg::PB_ACK1;
				sw1 <= b;
			end
			if (state == apt_pkg::T_T1RD && rx_take) begin
				sw1 <= b;
			end
			if (wd_go || (state == apt_pkg::T_RDATA && rx_take)) begin
				rem <= rem - 9'h001;
			end
			if (retry_le) begin
				hdr[4] <= b;
			end
			if (fetch || refetch) begin
				hdr[1] <= `APT_INS_GET_RESP;
				hdr[2] <= 8'h00;
				hdr[3] <= 8'h00;
				hdr[4] <= fetch ? b : 8'h00;
				wr <= 1'b0;
				grd <= grd | refetch;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link output and user results

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lnk.t2c_valid <= 1'b0;
			lnk.t2c_data <= 8'h00;
			wd_take <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			done <= 1'b0;
			done_sw <= 16'h0000;
		end else begin
			wd_take <= wd_go;
			if (hdr_go || wd_go) begin
				lnk.t2c_valid <= 1'b1;
				lnk.t2c_data <= hdr_go ? hdr[idx] : wd_data;
			end else if (lnk.t2c_ready) begin
				lnk.t2c_valid <= 1'b0;
			end
			rsp_valid <= rx_take && (state == apt_pkg::T_RDATA ||
				(state == apt_pkg::T_T1RD && !lnk.c2t_stat));
			if (rx_take) begin
				rsp_data <= b;
			end
			done <= state == apt_pkg::T_SW2 && rx_take && !retry_le && !fetch && !refetch;
			if (state == apt_pkg::T_SW2 && rx_take) begin
				done_sw <= {sw1, b};
			end
		end
	end

endmodule // apt_term

//--- tb_top.sv
// testbench: terminal end and card end joined by the link, user sides driven here
// assumes the design files and apt_params.svh are compiled first
`timescale 1ns/1ps
`include "apt_params.svh"

module tb_top;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0, req_write = 1'b0, req_t1 = 1'b0, req_ready;
	logic [7:0] req_ins = 8'h00, req_p2 = 8'h00, req_p3 = 8'h00;
	logic wd_valid = 1'b0, wd_take, rsp_valid, done, cmd_valid, cmd_phase, cmd_dvalid;
	logic [7:0] wd_data = 8'h00, rsp_data, cmd_data, cmd_ins, cmd_p3;
	logic [15:0] done_sw, got_sw;
	logic dec_valid = 1'b0, dec_ok = 1'b0, dec_bad_param = 1'b0, dec_read = 1'b0;
	logic dec_case4 = 1'b0, rd_valid = 1'b0, rd_ready, got_done;
	logic [7:0] dec_avail = 8'h00, rd_data = 8'h00, a_av0, a_av1;
	logic [15:0] dec_sw = 16'h0000;
	logic [7:0] c_log[$], t_log[$], r_log[$], d_log[$], rd_q[$], wd_q[$], fcp[$];
	logic [7:0] file_data[$] = {8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8,
		8'hA9, 8'h00, 8'h00};
	int check_count = 0;
	int bad_count = 0;

	initial forever #2 mclk = ~mclk;

	apt_link_if lnk();
	apt_term i_apt_term (.mclk(mclk), .arst_n(arst_n), .lnk(lnk), .req_valid(req_valid),
		.req_cla(8'h00), .req_ins(req_ins), .req_p1(8'h00), .req_p2(req_p2), .req_p3(req_p3),
		.req_write(req_write), .req_case4(req_write), .req_t1(req_t1), .req_ready(req_ready),
		.wd_valid(wd_valid), .wd_data(wd_data), .wd_take(wd_take), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .done(done), .done_sw(done_sw));
	apt_card i_apt_card (.mclk(mclk), .arst_n(arst_n), .lnk(lnk), .cmd_valid(cmd_valid),
		.cmd_phase(cmd_phase), .cmd_cla(), .cmd_ins(cmd_ins), .cmd_p1(), .cmd_p2(),
		.cmd_p3(cmd_p3),
		.cmd_dvalid(cmd_dvalid), .cmd_data(cmd_data), .dec_valid(dec_valid), .dec_ok(dec_ok),
		.dec_bad_param(dec_bad_param), .dec_read(dec_read), .dec_case4(dec_case4),
		.dec_avail(dec_avail), .dec_sw(dec_sw), .rd_valid(rd_valid), .rd_data(rd_data),
		.rd_ready(rd_ready));
	apt_link_assertions i_apt_link_assertions (.mclk(mclk), .arst_n(arst_n),
		.t2c_valid(lnk.t2c_valid), .t2c_data(lnk.t2c_data), .t2c_ready(lnk.t2c_ready),
		.c2t_valid(lnk.c2t_valid), .c2t_data(lnk.c2t_data), .c2t_stat(lnk.c2t_stat),
		.c2t_ready(lnk.c2t_ready), .t1_mode(lnk.t1_mode));

	////////////////////////////////////////////////////////////////
	// link and user monitors, application side of the card
	always @(posedge mclk) begin
		if (lnk.c2t_valid && lnk.c2t_ready) c_log.push_back(lnk.c2t_data);
		if (lnk.t2c_valid && lnk.t2c_ready) t_log.push_back(lnk.t2c_data);
		if (rsp_valid) r_log.push_back(rsp_data);
		if (cmd_dvalid) d_log.push_back(cmd_data);
		if (done) got_sw = done_sw;
		if (done) got_done = 1'b1;
		if (rd_valid && rd_ready) void'(rd_q.pop_front());
		if (wd_take && wd_q.size() > 0) void'(wd_q.pop_front());
	end

	always @(negedge mclk) begin
		rd_valid <= rd_q.size() > 0;
		rd_data <= (rd_q.size() > 0) ? rd_q[0] : 8'h00;
		wd_valid <= wd_q.size() > 0;
		wd_data <= (wd_q.size() > 0) ? wd_q[0] : 8'h00;
		dec_avail <= cmd_phase ? a_av1 : a_av0;
		if (cmd_valid) dec_valid <= 1'b1;
		else if (lnk.c2t_valid) dec_valid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic check_q(input string what, input logic [7:0] seen[$], input logic [7:0] exp[$]);
		check(what, 16'(seen.size()), 16'(exp.size()));
		foreach (exp[i]) if (i < seen.size()) check(what, {8'h00, seen[i]}, {8'h00, exp[i]});
	endtask

	task automatic app(input logic ok, bad, read, cs4, input logic [7:0] av0, av1,
		input logic [15:0] sw);
		{dec_ok, dec_bad_param, dec_read, dec_case4, a_av0, a_av1, dec_sw} =
			{ok, bad, read, cs4, av0, av1, sw};
	endtask

	// one command from the terminal user, waits for its end
	task automatic run(input logic [7:0] ins, p2, p3, input logic wr, t1);
		int n;
		c_log.delete();
		t_log.delete();
		r_log.delete();
		d_log.delete();
		got_done = 1'b0;
		{req_ins, req_p2, req_p3, req_write, req_t1} = {ins, p2, p3, wr, t1};
		req_valid = 1'b1;
		n = 0;
		while (!req_ready && n < 50) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		req_valid = 1'b0;
		while (!got_done && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		if (!got_done) begin
			check("done", 16'(got_done), 16'h0001);
			finish_test();
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic s_le_zero();
		app(1, 0, 1, 0, 8'h0B, 8'h00, `APT_SW_OK);
		rd_q = file_data;
		run(8'hB0, 8'h00, 8'h00, 1'b0, 1'b0);
		check_q("reply bytes", c_log, {8'h6C, 8'h0B, 8'hB0, file_data, 8'h90, 8'h00});
		check_q("header bytes", t_log, {8'h00, 8'hB0, 8'h00, 8'h00, 8'h00,
			8'h00, 8'hB0, 8'h00, 8'h00, 8'h0B});
		check_q("response data", r_log, file_data);
		check("final status", got_sw, `APT_SW_OK);
		check("header ins", {8'h00, cmd_ins}, 16'h00B0);
		check("header length", {8'h00, cmd_p3}, 16'h000B);
	endtask

	task automatic s_le_short();
		app(1, 0, 1, 0, 8'h0B, 8'h00, `APT_SW_OK);
		rd_q = file_data;
		run(8'hB0, 8'h00, 8'h05, 1'b0, 1'b0);
		check_q("reply bytes", c_log, {8'hB0, file_data[0:4], 8'h61, 8'h06, 8'hC0,
			file_data[5:10], 8'h90, 8'h00});
		check_q("response data", r_log, file_data);
		check("final status", got_sw, `APT_SW_OK);
	endtask

	task automatic s_bad_param();
		logic [7:0] lens[4] = '{8'h00, 8'h15, 8'h0B, 8'h05};
		foreach (lens[i]) begin
			app(0, 1, 1, 0, 8'h0B, 8'h00, `APT_SW_OK);
			run(8'hB0, 8'h7F, lens[i], 1'b0, 1'b0);
			check_q("reply bytes", c_log, {8'h6B, 8'h00});
			check("data count", 16'(r_log.size()), 16'h0000);
			check("final status", got_sw, `APT_SW_BAD_PARAM);
		end
	endtask

	task automatic s_select();
		for (int i = 0; i < 15; i++) fcp.push_back(8'h80 + 8'(i));
		app(1, 0, 0, 1, 8'h00, 8'h0F, `APT_SW_OK);
		rd_q = fcp;
		wd_q = {8'h6F, 8'h07};
		run(8'hA4, 8'h04, 8'h02, 1'b1, 1'b0);
		check_q("reply bytes", c_log, {8'hA4, 8'h61, 8'h0F, 8'hC0, fcp, 8'h90, 8'h00});
		check_q("file id", d_log, {8'h6F, 8'h07});
		check_q("response data", r_log, fcp);
		check("final status", got_sw, `APT_SW_OK);
	endtask

	// case 4 ending without data: plain ok, then a warning that is retried
	task automatic s_case4_status();
		logic [15:0] sws[2] = '{`APT_SW_OK, 16'h6283};
		foreach (sws[i]) begin
			app(1, 0, 0, 1, 8'h00, 8'h00, sws[i]);
			wd_q = {8'h6F, 8'h07};
			run(8'hA4, 8'h04, 8'h02, 1'b1, 1'b0);
			if (i == 0) check_q("reply bytes", c_log, {8'hA4, 8'h6F, 8'h00});
			else begin
				check_q("reply bytes", c_log, {8'hA4, 8'h62, 8'h83, 8'h6F, 8'h00});
				check_q("refetch header", t_log[7:11], {8'h00, 8'hC0, 8'h00, 8'h00, 8'h00});
			end
			check("final status", got_sw, `APT_SW_FAIL);
		end
	endtask

	task automatic s_block();
		app(1, 0, 0, 0, 8'h00, 8'h00, 16'h63C3);
		run(8'h20, 8'h01, 8'h00, 1'b0, 1'b1);
		check_q("reply bytes", c_log, {8'h63, 8'hC3});
		check("final status", got_sw, 16'h63C3);
		app(1, 0, 1, 0, 8'h0B, 8'h00, `APT_SW_OK);
		rd_q = file_data;
		run(8'hB0, 8'h00, 8'h0B, 1'b0, 1'b1);
		check_q("reply bytes", c_log, {file_data, 8'h90, 8'h00});
		check_q("response data", r_log, file_data);
	endtask

	initial begin
		repeat (6) @(negedge mclk);
		arst_n = 1'b1;
		@(negedge mclk);
		s_le_zero();
		s_le_short();
		s_bad_param();
		s_select();
		s_case4_status();
		s_block();
		finish_test();
	end
endmodule // tb_top
